// ### ack_partner.sv
`timescale 1ns/1ns
`default_nettype none
// --------------------------------
// Linked control system acknowledge model
// --------------------------------
module ack_partner(
    input wire logic clk,
    input wire logic go,
    output logic ack_pin
);
    // The linked acknowledge is asynchronous, so it moves off the edge.
    // A request gives a pulse long enough for the pin synchroniser.
    // One process owns the pin, so it has a single driver.
    initial
    begin
        ack_pin = 1'b0;
        forever
        begin
            @(posedge go);
            @(posedge clk);
            #7 ack_pin = 1'b1;
            repeat (4) @(posedge clk);
            #7 ack_pin = 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### fault_history_logger.sv
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Keep sixteen newest faults, newest first.
// - Slots three to sixteen follow in order.
// - Record holds hours, minutes and code.
// - Total fault counter never clears.
// - Hours readable and used as stamp.
// - Panel or linked input clears fault.
// - Auto clear only overcurrent and overvoltage.
// - Count automatic clears separately.
// - Active fault code readable separately.
// - No fault reads as code zero.
// - Overload group one, subcodes zero to three.
// - Sustained sixty seconds, short-term one second.
// - Heat sink group two, hot/cold.
// - Interior group three, subcodes zero, one, three.
// - Motor group four, subcode zero.
// - Maximum temperature trips and raises fault.
// - Warning five degrees below maximum, configurable.
module fault_history_logger
    import fault_log_pkg::*;
#(
    parameter int TW = 32,
    parameter logic [TW-1:0] LONG_CYC = TW'(LONG_OVLD_CYC),
    parameter logic [TW-1:0] SHORT_CYC = TW'(SHORT_OVLD_CYC)
)(
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic EXT_FAULT,
    input wire logic [6:0] EXT_GROUP,
    input wire logic [6:0] EXT_SUB,
    input wire logic OVLD_GEN,
    input wire logic OVLD_LOWF,
    input wire logic OVLD_LONG_LVL,
    input wire logic OVLD_SHORT_LVL,
    input wire logic [7:0] HS_TEMP,
    input wire logic [7:0] IN_TEMP,
    input wire logic [7:0] CAP_TEMP,
    input wire logic MOTOR_OT_PIN,
    input wire logic ACK_PIN,
    input wire logic [HRS_W-1:0] HOURS,
    input wire logic [MIN_W-1:0] MINUTES,
    output logic [CODE_W-1:0] FAULT_CODE,
    output logic TRIP,
    output logic HS_WARN,
    output logic IN_WARN,
    output logic IRQ
);

    // ----------------------------------------
    // State and registers
    // ----------------------------------------
    // Fault state machine.
    fault_state_t st_q;
    fault_state_t st_d;
    // Active fault code, zero while clear.
    logic [CODE_W-1:0] active_q;
    logic [CODE_W-1:0] active_d;
    // Fault counters.
    logic [31:0] total_q;
    logic [31:0] auto_q;
    // Automatic acknowledge enable.
    logic auto_en_q;
    // Sticky event status and its mask.
    logic [STAT_W-1:0] stat_q;
    logic [STAT_W-1:0] stat_d;
    logic [STAT_W-1:0] mask_q;
    // Thresholds in degrees.
    logic [7:0] warn_q;
    logic [7:0] hs_max_q;
    logic [7:0] hs_min_q;
    logic [7:0] in_max_q;
    logic [7:0] in_min_q;
    logic [7:0] cap_max_q;
    // Registered warning outputs and read data.
    logic hs_warn_q;
    logic in_warn_q;
    logic [31:0] rdata_q;
    // Pin synchronisers; stage one is read only by stage two.
    logic ack_s1_q;
    logic ack_s2_q;
    logic ack_s3_q;
    logic mot_s1_q;
    logic mot_s2_q;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // The acknowledge and motor sensor pins come from outside the clock domain.
    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            ack_s3_q <= 1'b0;
            mot_s1_q <= 1'b0;
            mot_s2_q <= 1'b0;
        end
        else
        begin
            ack_s1_q <= ACK_PIN;
            ack_s2_q <= ack_s1_q;
            ack_s3_q <= ack_s2_q;
            mot_s1_q <= MOTOR_OT_PIN;
            mot_s2_q <= mot_s1_q;
        end
    end

    // ----------------------------------------
    // Overload interval timers
    // ----------------------------------------
    // Hits after the level has stood a full interval.
    logic long_hit;
    logic short_hit;

    persist_timer #(.CW(TW), .LIMIT(LONG_CYC)) u_long
    (
        .clk(CLOCK),
        .rst(RST),
        .level(OVLD_LONG_LVL),
        .hit(long_hit)
    );

    persist_timer #(.CW(TW), .LIMIT(SHORT_CYC)) u_short
    (
        .clk(CLOCK),
        .rst(RST),
        .level(OVLD_SHORT_LVL),
        .hit(short_hit)
    );

    // ----------------------------------------
    // Temperature monitoring
    // ----------------------------------------
    // Reaching a maximum or falling below a minimum is a fault.
    wire hs_hot = (HS_TEMP >= hs_max_q);
    wire hs_cold = (HS_TEMP < hs_min_q);
    wire in_hot = (IN_TEMP >= in_max_q);
    wire in_cold = (IN_TEMP < in_min_q);
    wire cap_hot = (CAP_TEMP >= cap_max_q);
    // Warning band sums are one bit wider so they cannot wrap.
    wire hs_near = ({1'b0, HS_TEMP} + {1'b0, warn_q} >= {1'b0, hs_max_q});
    wire in_near = ({1'b0, IN_TEMP} + {1'b0, warn_q} >= {1'b0, in_max_q});
    wire warn_rise = (hs_near & ~hs_warn_q) | (in_near & ~in_warn_q);

    // ----------------------------------------
    // Fault selection
    // ----------------------------------------
    // Fixed priority; only the first fault while clear is taken, so a burst logs once.
    wire [CODE_W-1:0] new_code =
        EXT_FAULT ? code_of(EXT_GROUP, EXT_SUB) :
        hs_hot ? code_of(GRP_HS, SUB_0) :
        in_hot ? code_of(GRP_IN, SUB_0) :
        cap_hot ? code_of(GRP_IN, SUB_3) :
        mot_s2_q ? code_of(GRP_MOTOR, SUB_0) :
        short_hit ? code_of(GRP_OVLD, SUB_3) :
        long_hit ? code_of(GRP_OVLD, SUB_2) :
        OVLD_LOWF ? code_of(GRP_OVLD, SUB_1) :
        OVLD_GEN ? code_of(GRP_OVLD, SUB_0) :
        hs_cold ? code_of(GRP_HS, SUB_1) :
        in_cold ? code_of(GRP_IN, SUB_1) : CODE_NONE;
    wire new_valid = EXT_FAULT | hs_hot | in_hot | cap_hot | mot_s2_q | short_hit
        | long_hit | OVLD_LOWF | OVLD_GEN | hs_cold | in_cold;
    wire accept = new_valid && (st_q == ST_CLEAR);

    // ----------------------------------------
    // Acknowledge
    // ----------------------------------------
    // A panel write of the acknowledge bit or a rising linked input clears.
    wire wr_ctrl = WR && (ADDR == A_CTRL);
    wire panel_ack = wr_ctrl && WDATA[CTRL_ACK_BIT];
    wire link_ack = ack_s2_q & ~ack_s3_q;
    wire ext_ack = panel_ack | link_ack;
    // Only the two listed codes ever clear themselves.
    wire auto_code = (active_q == CODE_OVERCUR) || (active_q == CODE_OVERVOLT);
    wire auto_ack = auto_en_q && (st_q == ST_FAULT) && auto_code && !ext_ack;
    wire do_clear = (st_q == ST_FAULT) && (ext_ack | auto_ack);

    // ----------------------------------------
    // Fault state machine
    // ----------------------------------------
    // A condition still present after a clear is taken again next cycle.
    always_comb
    begin
        st_d = st_q;
        active_d = active_q;
        case (st_q)
            ST_CLEAR:
            begin
                if (accept)
                begin
                    st_d = ST_FAULT;
                    active_d = new_code;
                end
            end
            ST_FAULT:
            begin
                if (do_clear)
                begin
                    st_d = ST_CLEAR;
                    active_d = CODE_NONE;
                end
            end
            default:
            begin
                st_d = ST_CLEAR;
                active_d = CODE_NONE;
            end
        endcase
    end

    // ----------------------------------------
    // History store
    // ----------------------------------------
    // Each record is stamped with the live hours and minutes.
    wire [REC_W-1:0] new_rec = {HOURS, MINUTES, new_code};
    wire [REC_W-1:0] slot_rec;

    fault_history_store #(.DEPTH(HIST_DEPTH), .W(REC_W)) u_hist
    (
        .clk(CLOCK),
        .rst(RST),
        .push(accept),
        .rec_in(new_rec),
        .rd_idx(ADDR[3:0]),
        .rd_rec(slot_rec)
    );

    // ----------------------------------------
    // Status and interrupt
    // ----------------------------------------
    // Events: logged, cleared, cleared automatically, warning entered.
    wire rd_stat = RD && (ADDR == A_STAT);
    wire [STAT_W-1:0] stat_set = {warn_rise, auto_ack, do_clear, accept};
    // A set in the same cycle as the clearing read wins.
    assign stat_d = (rd_stat ? '0 : stat_q) | stat_set;

    // ----------------------------------------
    // Read decode
    // ----------------------------------------
    wire [31:0] rd_word =
        (ADDR == A_ACTIVE) ? {16'h0000, active_q} :
        (ADDR == A_TOTAL) ? total_q :
        (ADDR == A_AUTO) ? auto_q :
        (ADDR == A_HOURS) ? {9'h000, HOURS, MINUTES} :
        (ADDR == A_CTRL) ? {31'h00000000, auto_en_q} :
        (ADDR == A_STAT) ? {28'h0000000, stat_q} :
        (ADDR == A_MASK) ? {28'h0000000, mask_q} :
        (ADDR == A_WARN) ? {24'h000000, warn_q} :
        (ADDR == A_HS_MAX) ? {24'h000000, hs_max_q} :
        (ADDR == A_HS_MIN) ? {24'h000000, hs_min_q} :
        (ADDR == A_IN_MAX) ? {24'h000000, in_max_q} :
        (ADDR == A_IN_MIN) ? {24'h000000, in_min_q} :
        (ADDR == A_CAP_MAX) ? {24'h000000, cap_max_q} :
        (ADDR[7:4] == A_TIME_PAGE) ? {9'h000, slot_rec[REC_W-1:CODE_W]} :
        (ADDR[7:4] == A_CODE_PAGE) ? {16'h0000, slot_rec[CODE_W-1:0]} :
        32'h00000000;

    // ----------------------------------------
    // Fault registers
    // ----------------------------------------
    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            st_q <= ST_CLEAR;
            active_q <= CODE_NONE;
            total_q <= 32'h00000000;
            auto_q <= 32'h00000000;
        end
        else
        begin
            st_q <= st_d;
            active_q <= active_d;
            total_q <= total_q + {31'h00000000, accept};
            auto_q <= auto_q + {31'h00000000, auto_ack};
        end
    end

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    // Unmapped writes are dropped; only the low byte of a threshold is kept.
    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            auto_en_q <= 1'b0;
            mask_q <= '0;
            warn_q <= WARN_RST;
            hs_max_q <= HS_MAX_RST;
            hs_min_q <= HS_MIN_RST;
            in_max_q <= IN_MAX_RST;
            in_min_q <= IN_MIN_RST;
            cap_max_q <= CAP_MAX_RST;
        end
        else if (WR)
        begin
            if (ADDR == A_CTRL)
                auto_en_q <= WDATA[CTRL_AUTO_BIT];
            else if (ADDR == A_MASK)
                mask_q <= WDATA[STAT_W-1:0];
            else if (ADDR == A_WARN)
                warn_q <= WDATA[7:0];
            else if (ADDR == A_HS_MAX)
                hs_max_q <= WDATA[7:0];
            else if (ADDR == A_HS_MIN)
                hs_min_q <= WDATA[7:0];
            else if (ADDR == A_IN_MAX)
                in_max_q <= WDATA[7:0];
            else if (ADDR == A_IN_MIN)
                in_min_q <= WDATA[7:0];
            else if (ADDR == A_CAP_MAX)
                cap_max_q <= WDATA[7:0];
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            rdata_q <= 32'h00000000;
            stat_q <= '0;
            hs_warn_q <= 1'b0;
            in_warn_q <= 1'b0;
        end
        else
        begin
            rdata_q <= RD ? rd_word : 32'h00000000;
            stat_q <= stat_d;
            hs_warn_q <= hs_near;
            in_warn_q <= in_near;
        end
    end

    assign RDATA = rdata_q;
    assign FAULT_CODE = active_q;
    assign TRIP = (st_q == ST_FAULT);
    assign HS_WARN = hs_warn_q;
    assign IN_WARN = in_warn_q;
    assign IRQ = |(stat_q & mask_q);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_none_zero;
        @(posedge CLOCK) disable iff (RST) (st_q == ST_CLEAR) |-> (FAULT_CODE == CODE_NONE);
    endproperty
    a_none_zero: assert property (p_none_zero) else $error("clear but code set");

    property p_log_code;
        @(posedge CLOCK) disable iff (RST) accept |=> TRIP && FAULT_CODE == $past(new_code);
    endproperty
    a_log_code: assert property (p_log_code) else $error("active code wrong");

    property p_total;
        @(posedge CLOCK) disable iff (RST) accept |=> total_q == $past(total_q) + 32'h1;
    endproperty
    a_total: assert property (p_total) else $error("total count missed");

    property p_ack;
        @(posedge CLOCK) disable iff (RST) (TRIP && ext_ack) |=> !TRIP ##1 1'b1;
    endproperty
    a_ack: assert property (p_ack) else $error("acknowledge ignored");

    property p_auto;
        @(posedge CLOCK) disable iff (RST)
            (TRIP && auto_en_q && auto_code && !ext_ack)
            |=> !TRIP && auto_q == $past(auto_q) + 32'h1;
    endproperty
    a_auto: assert property (p_auto) else $error("auto clear failed");

    property p_no_auto;
        @(posedge CLOCK) disable iff (RST) (TRIP && !auto_code && !ext_ack) |=> TRIP;
    endproperty
    a_no_auto: assert property (p_no_auto) else $error("fault cleared itself");

    property p_hours;
        @(posedge CLOCK) disable iff (RST)
            (RD && ADDR == A_HOURS) |=> RDATA[22:0] == $past({HOURS, MINUTES});
    endproperty
    a_hours: assert property (p_hours) else $error("hours read wrong");

    property p_hot;
        @(posedge CLOCK) disable iff (RST)
            (!TRIP && hs_hot && !EXT_FAULT) |=> FAULT_CODE == 16'h0200;
    endproperty
    a_hot: assert property (p_hot) else $error("heat sink trip missing");

    property p_warn;
        @(posedge CLOCK) disable iff (RST) hs_near |=> HS_WARN;
    endproperty
    a_warn: assert property (p_warn) else $error("warning missing");

    c_log: cover property (@(posedge CLOCK) disable iff (RST) accept);
    c_auto: cover property (@(posedge CLOCK) disable iff (RST) auto_ack);
    c_link: cover property (@(posedge CLOCK) disable iff (RST) TRIP && link_ack);
endmodule
`default_nettype wire

// ### fault_history_logger_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module fault_history_logger_tb_top
    import fault_log_pkg::*;
;
    // --------------------------------
    // Stimulus and observed signals
    // --------------------------------
    logic clock, rst, wr, rd, ext, ovs, ovl, ovf, ovg, mot, ackgo, ackp;
    logic [7:0] addr, hs, tin;
    logic [31:0] wdata, rdata, v;
    logic [6:0] grp, sub;
    logic [16:0] hrs;
    logic [5:0] mins;
    logic [15:0] code;
    logic trip, hsw, inw, irq;
    int err_total, n_checks, nf;
    // Short overload counts keep the run brief.
    fault_history_logger #(.LONG_CYC(32'd20), .SHORT_CYC(32'd5)) fault_history_logger_i (
        .CLOCK(clock), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .EXT_FAULT(ext), .EXT_GROUP(grp), .EXT_SUB(sub),
        .OVLD_GEN(ovg), .OVLD_LOWF(ovf), .OVLD_LONG_LVL(ovl), .OVLD_SHORT_LVL(ovs),
        .HS_TEMP(hs), .IN_TEMP(tin), .CAP_TEMP(8'h19), .MOTOR_OT_PIN(mot),
        .ACK_PIN(ackp), .HOURS(hrs), .MINUTES(mins), .FAULT_CODE(code), .TRIP(trip),
        .HS_WARN(hsw), .IN_WARN(inw), .IRQ(irq));
    ack_partner ack_partner_i (.clk(clock), .go(ackgo), .ack_pin(ackp));
    // --------------------------------
    // Helpers
    // --------------------------------
    // Clock of 40 ns.
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // Compare and count; a mismatch is reported at once.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Expected four-digit code, worked out independently.
    function automatic logic [31:0] bcd(input int g, input int s);
        return {16'h0, 4'(g / 10), 4'(g % 10), 4'(s / 10), 4'(s % 10)};
    endfunction
    // Wait n edges and let their updates land.
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // One-cycle write.
    task automatic wrt(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    // One-cycle read; data stand only in the following cycle.
    task automatic rdr(input logic [7:0] a);
        @(posedge clock);
        addr <= a; rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    // External fault report for one cycle; the trip follows at once.
    task automatic fault(input int g, input int s);
        @(posedge clock);
        ext <= 1'b1; grp <= 7'(g); sub <= 7'(s);
        @(posedge clock);
        ext <= 1'b0;
        nf++;
        #1 chk(32'(trip), 32'h1);
        chk(32'(code), bcd(g, s));
    endtask
    // Panel acknowledge through the control register.
    task automatic ack();
        wrt(A_CTRL, 32'h2);
        tick(1);
        chk(32'(trip), 32'h0);
    endtask
    // Verdict and end of run.
    task automatic print_verdict();
        if (err_total == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // --------------------------------
    // Scenarios
    // --------------------------------
    // Reset values, thresholds and an unmapped read.
    task automatic s_reset();
        chk(32'(code), 32'h0);
        rdr(A_WARN); chk(v, 32'h5);
        rdr(A_HS_MAX); chk(v, 32'h5a);
        rdr(8'hff); chk(v, 32'h0);
    endtask
    // Auto clear of overcurrent only, and the linked acknowledge.
    task automatic s_auto();
        wrt(A_CTRL, 32'h1);
        fault(5, 7);
        tick(1); chk(32'(trip), 32'h0);
        rdr(A_AUTO); chk(v, 32'h1);
        fault(3, 1);
        tick(3); chk(32'(trip), 32'h1);
        @(posedge clock) ackgo <= 1'b1;
        @(posedge clock) ackgo <= 1'b0;
        tick(12); chk(32'(trip), 32'h0);
        rdr(A_AUTO); chk(v, 32'h1);
    endtask
    // Masked interrupt raised by logging and cleared by the status read.
    task automatic s_irq();
        wrt(A_MASK, 32'h1);
        rdr(A_STAT);
        fault(4, 4);
        chk(32'(irq), 32'h1);
        rdr(A_STAT); chk(32'(v[0]), 32'h1);
        chk(32'(irq), 32'h0);
        wrt(A_MASK, 32'h0);
        ack();
    endtask
    // Seventeen faults: the first falls out, the rest stay newest first.
    task automatic s_hist();
        for (int i = 0; i < 17; i++)
        begin
            @(posedge clock);
            hrs <= 17'(i * 1000 + 7); mins <= 6'(i);
            fault(10 + i, i);
            ack();
        end
        for (int k = 0; k < 16; k++)
        begin
            rdr(8'h30 + 8'(k)); chk(v, bcd(26 - k, 16 - k));
            rdr(8'h20 + 8'(k)); chk(v, 32'({17'((16 - k) * 1000 + 7), 6'(16 - k)}));
        end
        rdr(A_HOURS); chk(v, 32'({hrs, mins}));
    endtask
    // Temperature, overload, motor and under-temperature sources.
    task automatic s_src();
        @(posedge clock) hs <= 8'd85;
        tick(3); chk(32'(hsw), 32'h1);
        chk(32'(trip), 32'h0);
        @(posedge clock) hs <= 8'd90;
        tick(3); chk(32'(code), 32'h0200);
        @(posedge clock) hs <= 8'd25;
        tick(2); ack();
        // A wider warning band shows that the offset is configurable.
        wrt(A_WARN, 32'd10);
        @(posedge clock) tin <= 8'd60;
        tick(3); chk(32'(inw), 32'h1);
        chk(32'(trip), 32'h0);
        @(posedge clock) tin <= 8'd70;
        tick(3); chk(32'(code), 32'h0300);
        @(posedge clock) tin <= 8'd25;
        tick(2); ack();
        wrt(A_IN_MIN, 32'd30);
        tick(1); chk(32'(code), 32'h0301);
        wrt(A_IN_MIN, 32'd0);
        ack();
        @(posedge clock) ovs <= 1'b1;
        tick(2); chk(32'(trip), 32'h0);
        tick(8); chk(32'(code), 32'h0103);
        @(posedge clock) ovs <= 1'b0;
        tick(1); ack();
        // The long level trips exactly one cycle after its count is reached.
        @(posedge clock) ovl <= 1'b1;
        tick(20); chk(32'(trip), 32'h0);
        tick(1); chk(32'(code), 32'h0102);
        @(posedge clock) ovl <= 1'b0;
        tick(1); ack();
        @(posedge clock) ovf <= 1'b1;
        tick(1); chk(32'(code), 32'h0101);
        @(posedge clock) ovf <= 1'b0;
        tick(1); ack();
        @(posedge clock) ovg <= 1'b1;
        tick(1); chk(32'(code), 32'h0100);
        @(posedge clock) ovg <= 1'b0;
        tick(1); ack();
        @(posedge clock) mot <= 1'b1;
        tick(6); chk(32'(code), 32'h0400);
        @(posedge clock) mot <= 1'b0;
        tick(4); ack();
        nf += 8;
        rdr(A_TOTAL); chk(v, 32'(nf));
    endtask
    // --------------------------------
    // Main sequence and watchdog
    // --------------------------------
    initial
    begin
        {rst, wr, rd, ext, ovs, ovl, ovf, ovg, mot, ackgo} = 10'h200;
        {addr, hs, tin, wdata, grp, sub, hrs, mins} = '0;
        err_total = 0; n_checks = 0; nf = 0;
        tick(3);
        rst <= 1'b0;
        tick(3);
        s_reset();
        s_auto();
        s_irq();
        s_hist();
        s_src();
        print_verdict();
    end
    // The run needs about 340 cycles; this cuts a hang short.
    initial
    begin
        #2000000;
        err_total++;
        print_verdict();
    end
endmodule
`default_nettype wire

// ### fault_history_store.sv
`timescale 1ns/1ns
`default_nettype none
// Sixteen-deep shift store of fault records, newest in slot zero.
module fault_history_store
    import fault_log_pkg::*;
#(
    parameter int DEPTH = HIST_DEPTH,
    parameter int W = REC_W
)(
    input wire logic clk,
    input wire logic rst,
    input wire logic push,
    input wire logic [W-1:0] rec_in,
    input wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output logic [W-1:0] rd_rec
);
    // Record storage, index zero is the newest.
    logic [W-1:0] mem_q [DEPTH];

    // ----------------------------------------
    // Shift on push
    // ----------------------------------------
    // Every slot moves one older and the oldest falls off.
    always_ff @(posedge clk)
    begin
        if (rst)
            mem_q <= '{default: '0};
        else if (push)
        begin
            // The new record lands in the newest slot in the same update.
            mem_q[0] <= rec_in;
            for (int i = 1; i < DEPTH; i++)
                mem_q[i] <= mem_q[i-1];
        end
    end

    assign rd_rec = mem_q[rd_idx];

    property p_newest;
        @(posedge clk) disable iff (rst) push |=> mem_q[0] == $past(rec_in);
    endproperty
    a_newest: assert property (p_newest) else $error("newest slot wrong");
    property p_shift;
        @(posedge clk) disable iff (rst) push |=> mem_q[DEPTH-1] == $past(mem_q[DEPTH-2]);
    endproperty
    a_shift: assert property (p_shift) else $error("history did not shift");
endmodule
`default_nettype wire

// ### fault_log_pkg.sv
`default_nettype none
package fault_log_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    // System clock rate in hertz.
    localparam int CLK_HZ = 25_000_000;
    // Sustained overload judging interval in seconds.
    localparam int LONG_OVLD_S = 60;
    // Short-term overload judging interval in seconds.
    localparam int SHORT_OVLD_S = 1;
    // Interval lengths in clock cycles.
    localparam int LONG_OVLD_CYC = LONG_OVLD_S * CLK_HZ;
    localparam int SHORT_OVLD_CYC = SHORT_OVLD_S * CLK_HZ;

    // ----------------------------------------
    // Record layout
    // ----------------------------------------
    localparam int HIST_DEPTH = 16;
    localparam int HRS_W = 17;
    localparam int MIN_W = 6;
    localparam int CODE_W = 16;
    localparam int REC_W = HRS_W + MIN_W + CODE_W;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] A_ACTIVE = 8'h00;
    localparam logic [7:0] A_TOTAL = 8'h01;
    localparam logic [7:0] A_AUTO = 8'h02;
    localparam logic [7:0] A_HOURS = 8'h03;
    localparam logic [7:0] A_CTRL = 8'h04;
    localparam logic [7:0] A_STAT = 8'h05;
    localparam logic [7:0] A_MASK = 8'h06;
    localparam logic [7:0] A_WARN = 8'h07;
    localparam logic [7:0] A_HS_MAX = 8'h08;
    localparam logic [7:0] A_HS_MIN = 8'h09;
    localparam logic [7:0] A_IN_MAX = 8'h0a;
    localparam logic [7:0] A_IN_MIN = 8'h0b;
    localparam logic [7:0] A_CAP_MAX = 8'h0c;
    localparam logic [3:0] A_TIME_PAGE = 4'h2;
    localparam logic [3:0] A_CODE_PAGE = 4'h3;

    // Reset values of the threshold registers, in degrees.
    localparam logic [7:0] WARN_RST = 8'h05;
    localparam logic [7:0] HS_MAX_RST = 8'h5a;
    localparam logic [7:0] HS_MIN_RST = 8'h00;
    localparam logic [7:0] IN_MAX_RST = 8'h46;
    localparam logic [7:0] IN_MIN_RST = 8'h00;
    localparam logic [7:0] CAP_MAX_RST = 8'h55;

    // Control and status bit positions.
    localparam int CTRL_AUTO_BIT = 0;
    localparam int CTRL_ACK_BIT = 1;
    localparam int STAT_W = 4;

    // ----------------------------------------
    // Fault codes
    // ----------------------------------------
    localparam logic [6:0] GRP_OVLD = 7'h01;
    localparam logic [6:0] GRP_HS = 7'h02;
    localparam logic [6:0] GRP_IN = 7'h03;
    localparam logic [6:0] GRP_MOTOR = 7'h04;
    localparam logic [6:0] SUB_0 = 7'h00;
    localparam logic [6:0] SUB_1 = 7'h01;
    localparam logic [6:0] SUB_2 = 7'h02;
    localparam logic [6:0] SUB_3 = 7'h03;
    localparam logic [15:0] CODE_NONE = 16'h0000;
    localparam logic [15:0] CODE_OVERCUR = 16'h0507;
    localparam logic [15:0] CODE_OVERVOLT = 16'h0700;

    // Fault state: clear or holding an active fault.
    typedef enum logic {ST_CLEAR = 1'b0, ST_FAULT = 1'b1} fault_state_t;

    // Two decimal digits of a value below one hundred.
    function automatic logic [7:0] bcd2(input logic [6:0] v);
        logic [6:0] tens;
        tens = v / 7'd10;
        bcd2 = {tens[3:0], 4'(v - tens * 7'd10)};
    endfunction

    // Four-digit code from a group and a subcode.
    function automatic logic [15:0] code_of(input logic [6:0] grp, input logic [6:0] sub);
        code_of = {bcd2(grp), bcd2(sub)};
    endfunction

endpackage
`default_nettype wire

// ### persist_timer.sv
`timescale 1ns/1ns
`default_nettype none
// Flags a level that has stood for a whole interval.
module persist_timer
    import fault_log_pkg::*;
#(
    parameter int CW = 32,
    parameter logic [CW-1:0] LIMIT = CW'(SHORT_OVLD_CYC)
)(
    input wire logic clk,
    input wire logic rst,
    input wire logic level,
    output logic hit
);
    // Cycles the level has stood so far; saturates at the limit.
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    // Any drop of the level restarts the interval.
    assign cnt_d = !level ? '0 : (cnt_q == LIMIT) ? cnt_q : cnt_q + 1'b1;
    assign hit = (cnt_q == LIMIT);

    // Counter register.
    always_ff @(posedge clk)
    begin
        if (rst)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end

    // A drop of the level ends the flag at the next edge.
    property p_drop;
        @(posedge clk) disable iff (rst) !level |=> !hit;
    endproperty
    a_drop: assert property (p_drop) else $error("timer held after drop");
endmodule
`default_nettype wire
